// ===== core/uhea_top.sv
// Host endpoint attributes, interval timers and data ports
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module uhea_top
   import uhea_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic RSTN_I,
   input wire logic AXI_AWVALID_I,
   output logic AXI_AWREADY_O,
   input wire logic [11:0] AXI_AWADDR_I,
   input wire logic AXI_WVALID_I,
   output logic AXI_WREADY_O,
   input wire logic [31:0] AXI_WDATA_I,
   input wire logic [3:0] AXI_WSTRB_I,
   output logic AXI_BVALID_O,
   input wire logic AXI_BREADY_I,
   output logic [1:0] AXI_BRESP_O,
   input wire logic AXI_ARVALID_I,
   output logic AXI_ARREADY_O,
   input wire logic [11:0] AXI_ARADDR_I,
   output logic AXI_RVALID_O,
   input wire logic AXI_RREADY_I,
   output logic [31:0] AXI_RDATA_O,
   output logic [1:0] AXI_RRESP_O,
   input wire logic FRAME_TICK_I,
   input wire logic [8:0] NAK_I,
   input wire logic [8:0] XFER_OK_I,
   output logic [8:0] POLL_O,
   output logic [8:0] HALT_O,
   output uhea_pkg::uhea_type_s [4:0] TX_TYPE_O,
   output uhea_pkg::uhea_type_s [4:0] RX_TYPE_O,
   output logic [4:0] TX_VALID_O,
   input wire logic [4:0] TX_READY_I,
   output logic [31:0] TX_DATA_O,
   input wire logic [4:0] RX_VALID_I,
   input wire logic [4:0][31:0] RX_DATA_I,
   output logic [4:0] RX_READY_O,
   input wire logic B_SIDE_I,
   output logic SESSION_O,
   output logic HOST_REQ_O
);
   import uhea_pkg::*;

   //----------------------------------------------------------
   // State
   //----------------------------------------------------------
   typedef struct packed
   {
      logic [7:0] nak0;            // Control endpoint limit
      uhea_type_s [4:0] txt;       // Transmit type per endpoint
      uhea_type_s [4:0] rxt;       // Receive type per endpoint
      logic [3:0][7:0] txi;        // Transmit interval, ep 1-4
      logic [3:0][7:0] rxi;        // Receive interval, ep 1-4
      logic sess;                  // Session request
      logic hreq;                  // Host negotiation request
      logic b0;                    // Role pin, first stage
      logic b1;                    // Role pin, synchronised
      logic [NCH-1:0] halt;        // Halted channels
      logic [NCH-1:0] streak;      // NAK stream running
      logic [NCH-1:0] poll;        // Poll pulses
      logic [NCH-1:0][15:0] cnt;   // Frame counters
      logic aw_got;                // Write address held
      logic w_got;                 // Write data held
      logic [11:0] awa;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [4:0] tx_pend;         // Push waiting for FIFO
      logic [31:0] tx_data;
      logic [4:0] rx_pop;          // Pop pulses
   } uhea_state_s;

   uhea_state_s st_r;
   uhea_state_s st_nxt;
   uhea_tmr_s cfg;                 // Timer setting in the loop
   logic hit;                      // Write address decoded
   logic [11:0] ra;                // Read address

   //----------------------------------------------------------
   // Timer decode
   //----------------------------------------------------------
   // Turns type and interval into enable, mode and frame limit.
   // Exponents above 16 clamp so the counter never overflows.
   function automatic uhea_tmr_s tmr_cfg(input uhea_type_s t,
                                         input logic [7:0] v,
                                         input logic ctl);
      uhea_tmr_s r;
      logic [7:0] mc;
      logic [3:0] sh;
      logic [15:0] pw;
      r = '0;
      mc = (v > EXP_MAX) ? EXP_MAX : v;
      sh = (mc == 8'h00) ? 4'h0 : 4'(mc - 8'h01);
      pw = 16'h0001 << sh;
      if (ctl || t.protocol_select == PR_BULK)
      begin
         r.nak = 1'b1;
         r.en = (mc >= 8'h02);
         r.lim = pw;
      end
      else if (t.protocol_select == PR_INTR && t.speed != SPD_HIGH)
      begin
         r.en = (v != 8'h00);
         r.lim = {8'h00, v};
      end
      else if (t.protocol_select != PR_CTRL)
      begin
         r.en = (mc != 8'h00);
         r.lim = pw;
      end
      return r;
   endfunction

   //----------------------------------------------------------
   // Next state
   //----------------------------------------------------------
   // Bus slave first, timers after, so a halt set in the same
   // cycle as a software clear survives.
   always_comb
   begin
      st_nxt = st_r;
      hit = 1'b0;
      cfg = '0;
      ra = AXI_ARADDR_I;
      st_nxt.b0 = B_SIDE_I;
      st_nxt.b1 = st_r.b0;
      st_nxt.poll = '0;
      st_nxt.rx_pop = '0;
      // Capture address and data in either order
      if (AXI_AWVALID_I && AXI_AWREADY_O)
      begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awa = AXI_AWADDR_I;
      end
      if (AXI_WVALID_I && AXI_WREADY_O)
      begin
         st_nxt.w_got = 1'b1;
         st_nxt.wd = AXI_WDATA_I;
         st_nxt.ws = AXI_WSTRB_I;
      end
      // Perform the write once both halves are held and no push is pending
      if (st_r.aw_got && st_r.w_got && st_r.tx_pend == 5'h00)
      begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         unique case (st_r.awa)
            A_NAK0:
            begin
               hit = 1'b1;
               if (st_r.ws[0])
                  st_nxt.nak0 = {3'h0, st_r.wd[4:0]};
            end
            A_CAP: hit = 1'b1;
            A_DEV:
            begin
               hit = 1'b1;
               // Role bit stays read-only
               if (st_r.ws[0])
               begin
                  st_nxt.sess = st_r.wd[DEV_SESS];
                  st_nxt.hreq = st_r.wd[DEV_HREQ];
               end
            end
            A_HALT:
            begin
               hit = 1'b1;
               // Write one to clear, which also clears the flag
               st_nxt.halt = st_r.halt & ~st_r.wd[NCH-1:0];
            end
            default: hit = 1'b0;
         endcase
         for (int e = 0; e < 5; e++)
         begin
            if (st_r.awa == A_TXTYPE + 12'(e * 4))
            begin
               hit = 1'b1;
               if (st_r.ws[0])
                  st_nxt.txt[e] = uhea_type_s'(st_r.wd[7:0]);
            end
            if (st_r.awa == A_RXTYPE + 12'(e * 4))
            begin
               hit = 1'b1;
               if (st_r.ws[0])
                  st_nxt.rxt[e] = uhea_type_s'(st_r.wd[7:0]);
            end
            // Endpoint 0 has no interval slot
            if (e > 0 && st_r.awa == A_TXINT + 12'(e * 4))
            begin
               hit = 1'b1;
               if (st_r.ws[0])
                  st_nxt.txi[e-1] = st_r.wd[7:0];
            end
            if (e > 0 && st_r.awa == A_RXINT + 12'(e * 4))
            begin
               hit = 1'b1;
               if (st_r.ws[0])
                  st_nxt.rxi[e-1] = st_r.wd[7:0];
            end
            if (st_r.awa == A_DATA + 12'(e * 4))
            begin
               hit = 1'b1;
               st_nxt.tx_pend[e] = 1'b1;
               st_nxt.tx_data = st_r.wd;
            end
         end
         // Data port writes answer only after the push
         if (!hit || st_r.awa < A_DATA || st_r.awa >= A_DATA + 12'h014)
         begin
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
      // A full FIFO stalls the response, which stalls the master
      if (|(st_r.tx_pend & TX_READY_I))
      begin
         st_nxt.tx_pend = 5'h00;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = RESP_OKAY;
      end
      if (st_r.bvalid && AXI_BREADY_I)
         st_nxt.bvalid = 1'b0;
      // Read: answer the cycle after the address is taken
      if (AXI_ARVALID_I && AXI_ARREADY_O)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = RESP_OKAY;
         st_nxt.rdata = 32'h0000_0000;
         unique case (ra)
            A_NAK0: st_nxt.rdata[7:0] = st_r.nak0;
            A_CAP: st_nxt.rdata[7:0] = CAP_RESET;
            A_DEV:
            begin
               st_nxt.rdata[DEV_ROLE] = st_r.b1;
               st_nxt.rdata[DEV_HREQ] = st_r.hreq;
               st_nxt.rdata[DEV_SESS] = st_r.sess;
            end
            A_HALT: st_nxt.rdata[NCH-1:0] = st_r.halt;
            default: st_nxt.rresp = RESP_SLVERR;
         endcase
         for (int e = 0; e < 5; e++)
         begin
            if (ra == A_TXTYPE + 12'(e * 4))
            begin
               st_nxt.rresp = RESP_OKAY;
               st_nxt.rdata[7:0] = st_r.txt[e];
            end
            if (ra == A_RXTYPE + 12'(e * 4))
            begin
               st_nxt.rresp = RESP_OKAY;
               st_nxt.rdata[7:0] = st_r.rxt[e];
            end
            if (e > 0 && ra == A_TXINT + 12'(e * 4))
            begin
               st_nxt.rresp = RESP_OKAY;
               st_nxt.rdata[7:0] = st_r.txi[e-1];
            end
            if (e > 0 && ra == A_RXINT + 12'(e * 4))
            begin
               st_nxt.rresp = RESP_OKAY;
               st_nxt.rdata[7:0] = st_r.rxi[e-1];
            end
            // Empty FIFO reads zero and pops nothing
            if (ra == A_DATA + 12'(e * 4))
            begin
               st_nxt.rresp = RESP_OKAY;
               if (RX_VALID_I[e])
               begin
                  st_nxt.rdata = RX_DATA_I[e];
                  st_nxt.rx_pop[e] = 1'b1;
               end
            end
         end
      end
      else if (st_r.rvalid && AXI_RREADY_I)
         st_nxt.rvalid = 1'b0;
      // Channel timers: 0 control, 1-4 transmit, 5-8 receive
      for (int c = 0; c < NCH; c++)
      begin
         if (c == 0)
            cfg = tmr_cfg(st_r.txt[0], st_r.nak0, 1'b1);
         else if (c < 5)
            cfg = tmr_cfg(st_r.txt[c], st_r.txi[c-1], 1'b0);
         else
            cfg = tmr_cfg(st_r.rxt[c-4], st_r.rxi[c-5], 1'b0);
         if (!cfg.en || st_r.halt[c])
         begin
            st_nxt.cnt[c] = 16'h0000;
            st_nxt.streak[c] = 1'b0;
         end
         else if (cfg.nak)
         begin
            // Any non-NAK answer ends the stream
            if (XFER_OK_I[c])
            begin
               st_nxt.streak[c] = 1'b0;
               st_nxt.cnt[c] = 16'h0000;
            end
            else
            begin
               // Idle stream holds the counter at zero, so a count left
               // over from polling never shortens the first NAK limit
               if (!st_r.streak[c])
                  st_nxt.cnt[c] = 16'h0000;
               if (NAK_I[c])
                  st_nxt.streak[c] = 1'b1;
               if (FRAME_TICK_I && st_r.streak[c])
               begin
                  if ({1'b0, st_r.cnt[c]} + 17'h00001 >= {1'b0, cfg.lim})
                  begin
                     st_nxt.halt[c] = 1'b1;
                     st_nxt.streak[c] = 1'b0;
                     st_nxt.cnt[c] = 16'h0000;
                  end
                  else
                     st_nxt.cnt[c] = st_r.cnt[c] + 16'h0001;
               end
            end
         end
         else if (FRAME_TICK_I)
         begin
            // Polling: one pulse every lim frames
            if ({1'b0, st_r.cnt[c]} + 17'h00001 >= {1'b0, cfg.lim})
            begin
               st_nxt.poll[c] = 1'b1;
               st_nxt.cnt[c] = 16'h0000;
            end
            else
               st_nxt.cnt[c] = st_r.cnt[c] + 16'h0001;
         end
      end
   end

   //----------------------------------------------------------
   // Registers and outputs
   //----------------------------------------------------------
   // All control state starts at zero
   always_ff @(posedge REF_CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign AXI_AWREADY_O = !st_r.aw_got && !st_r.bvalid;
   assign AXI_WREADY_O = !st_r.w_got && !st_r.bvalid;
   assign AXI_BVALID_O = st_r.bvalid;
   assign AXI_BRESP_O = st_r.bresp;
   assign AXI_ARREADY_O = !st_r.rvalid;
   assign AXI_RVALID_O = st_r.rvalid;
   assign AXI_RDATA_O = st_r.rdata;
   assign AXI_RRESP_O = st_r.rresp;
   assign POLL_O = st_r.poll;
   assign HALT_O = st_r.halt;
   assign TX_TYPE_O = st_r.txt;
   assign RX_TYPE_O = st_r.rxt;
   assign TX_VALID_O = st_r.tx_pend;
   assign TX_DATA_O = st_r.tx_data;
   assign RX_READY_O = st_r.rx_pop;
   assign SESSION_O = st_r.sess;
   assign HOST_REQ_O = st_r.hreq;

   //----------------------------------------------------------
   // Checks
   //----------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RSTN_I);

   sequence push_taken;
      TX_VALID_O[1] && TX_READY_I[1];
   endsequence

   chk_cap_value: assert property (
      AXI_ARVALID_I && AXI_ARREADY_O && AXI_ARADDR_I == A_CAP
      |=> AXI_RDATA_O == 32'h0000_0006 && AXI_RRESP_O == RESP_OKAY)
      else $error("capability read wrong");
   chk_nak0_halt: assert property (
      $rose(st_r.halt[0]) |-> $past(FRAME_TICK_I) && $past(st_r.streak[0]))
      else $error("control halt without NAK frame");
   chk_nak_off: assert property (
      st_r.nak0[4:1] == 4'h0 |=> !$rose(st_r.halt[0]))
      else $error("control halt with timeout off");
   chk_poll_every: assert property (
      FRAME_TICK_I && st_r.txt[1].protocol_select == PR_INTR && st_r.txt[1].speed == SPD_FULL
      && st_r.txi[0] == 8'h01 && !st_r.halt[1] |=> POLL_O[1])
      else $error("interval one missed poll");
   chk_poll_pow: assert property (
      FRAME_TICK_I && st_r.rxt[1].protocol_select == PR_ISO && st_r.rxi[0] == 8'h02
      && st_r.cnt[5] == 16'h0000 |=> !POLL_O[5] && st_r.cnt[5] == 16'h0001)
      else $error("iso poll too early");
   chk_rx_bulk_flag: assert property (
      $rose(st_r.halt[5]) |-> $past(st_r.rxt[1].protocol_select) == PR_BULK)
      else $error("receive flag set off bulk");
   chk_push_resp: assert property (
      push_taken |=> AXI_BVALID_O && !TX_VALID_O[1] ##1 !TX_VALID_O[1])
      else $error("push not answered");
   chk_pop_data: assert property (
      AXI_ARVALID_I && AXI_ARREADY_O && AXI_ARADDR_I == A_DATA + A_STEP
      && RX_VALID_I[1] |=> RX_READY_O[1] && AXI_RDATA_O == $past(RX_DATA_I[1]))
      else $error("pop lost data");
   chk_role_read: assert property (
      AXI_ARVALID_I && AXI_ARREADY_O && AXI_ARADDR_I == A_DEV
      |=> AXI_RDATA_O[7] == $past(st_r.b1))
      else $error("role bit wrong");
endmodule

// ===== core/uhea_pkg.sv
// Constants and types of the host endpoint attribute block
//----------------------------------------------------------
//----------------------------------------------------------
package uhea_pkg;
   // Byte offsets of the register map
   localparam logic [11:0] A_NAK0 = 12'h000;
   localparam logic [11:0] A_CAP = 12'h004;
   localparam logic [11:0] A_DEV = 12'h008;
   localparam logic [11:0] A_HALT = 12'h00C;
   localparam logic [11:0] A_TXTYPE = 12'h010;
   localparam logic [11:0] A_RXTYPE = 12'h030;
   localparam logic [11:0] A_TXINT = 12'h050;
   localparam logic [11:0] A_RXINT = 12'h070;
   localparam logic [11:0] A_DATA = 12'h100;
   localparam logic [11:0] A_STEP = 12'h004;
   // Field positions and reset values
   localparam int DEV_ROLE = 7;
   localparam int DEV_HREQ = 1;
   localparam int DEV_SESS = 0;
   localparam logic [7:0] CAP_RESET = 8'h06;
   localparam logic [7:0] EXP_MAX = 8'h10;
   localparam int NCH = 9;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Target speed and transaction protocol codes
   typedef enum logic [1:0] {SPD_ILLEGAL, SPD_HIGH, SPD_FULL, SPD_LOW} uhea_speed_e;
   typedef enum logic [1:0] {PR_CTRL, PR_ISO, PR_BULK, PR_INTR} uhea_protocol_select_e;
   // One type register as seen by the transaction engine
   typedef struct packed
   {
      uhea_speed_e speed;
      uhea_protocol_select_e protocol_select;
      logic [3:0] target_ep;
   } uhea_type_s;
   // Decoded timer setting of one channel
   typedef struct packed
   {
      logic en;
      logic nak;
      logic [15:0] lim;
   } uhea_tmr_s;
endpackage

// ===== dv/uhea_usb_far.sv
// Far-side model: frame timer, NAKing targets, transmit and receive FIFOs
`timescale 1ns/1ps
module uhea_usb_far
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [8:0] nak_mask_i,
   input wire logic [4:0] tx_valid_i,
   input wire logic [31:0] tx_data_i,
   input wire logic [4:0] rx_ready_i,
   output logic tick_o,
   output logic [8:0] nak_o,
   output logic [4:0] tx_ready_o,
   output logic [4:0] rx_valid_o,
   output logic [4:0][31:0] rx_data_o,
   output logic [31:0] last_tx_o,
   output logic [2:0] last_ep_o
);
   //----------------------------------------------------------
   // Frame timer and NAK stream
   //----------------------------------------------------------
   logic [3:0] cyc_r; // Cycle within one frame
   logic [4:0][15:0] pop_r; // Words popped per receive FIFO
   // NAKs land mid-frame, so a stream never starts on a tick
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cyc_r <= 4'h0;
         pop_r <= '0;
         last_tx_o <= 32'h0;
         last_ep_o <= 3'h0;
      end
      else
      begin
         cyc_r <= cyc_r + 4'h1;
         for (int e = 0; e < 5; e++)
         begin
            // Pop advances the head word of that FIFO
            if (rx_ready_i[e])
               pop_r[e] <= pop_r[e] + 16'h1;
            // Record every word the transmit side accepts
            if (tx_valid_i[e] && tx_ready_o[e])
            begin
               last_tx_o <= tx_data_i;
               last_ep_o <= 3'(e);
            end
         end
      end
   end
   assign tick_o = (cyc_r == 4'hF);
   assign nak_o = (cyc_r == 4'h7) ? nak_mask_i : 9'h0;
   // Transmit FIFOs stall half the time, so a slow answer is seen
   assign tx_ready_o = {5{cyc_r[1]}};
   // Endpoint 0 receive FIFO stays empty
   assign rx_valid_o = 5'h1E;
   always_comb
   begin
      for (int e = 0; e < 5; e++)
         rx_data_o[e] = {8'hD0, 8'(e), pop_r[e]};
   end
endmodule

// ===== dv/tb.sv
// Self-checking bench of the host endpoint attribute block
`timescale 1ns/1ps
module tb;
   import uhea_pkg::*;
   //----------------------------------------------------------
   // Stimulus and observed signals
   //----------------------------------------------------------
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, bside = 1'b0;
   logic [11:0] aw = 12'h0, ar = 12'h0;
   logic [31:0] wd = 32'h0;
   logic [8:0] nak_mask = 9'h0;
   logic [8:0] xok = 9'h0; // Non-NAK answers per channel
   logic awr, wr, bv, arr, rv, tick, sess, hreq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, txd, last_tx;
   logic [8:0] nak, pollv, halt;
   uhea_type_s [4:0] txt, rxt;
   logic [4:0] txv, txr, rxv, rxr;
   logic [4:0][31:0] rxd;
   logic [2:0] last_ep;
   int mismatches = 0, n_compared = 0, cycles = 0;
   always #2 clk = ~clk;
   uhea_top i_uhea_top (.REF_CLK_I(clk), .RSTN_I(rstn), .AXI_AWVALID_I(awv),
      .AXI_AWREADY_O(awr), .AXI_AWADDR_I(aw), .AXI_WVALID_I(wv), .AXI_WREADY_O(wr),
      .AXI_WDATA_I(wd), .AXI_WSTRB_I(4'hF), .AXI_BVALID_O(bv), .AXI_BREADY_I(br),
      .AXI_BRESP_O(bresp), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_ARADDR_I(ar),
      .AXI_RVALID_O(rv), .AXI_RREADY_I(rr), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
      .FRAME_TICK_I(tick), .NAK_I(nak), .XFER_OK_I(xok), .POLL_O(pollv), .HALT_O(halt),
      .TX_TYPE_O(txt), .RX_TYPE_O(rxt), .TX_VALID_O(txv), .TX_READY_I(txr),
      .TX_DATA_O(txd), .RX_VALID_I(rxv), .RX_DATA_I(rxd), .RX_READY_O(rxr),
      .B_SIDE_I(bside), .SESSION_O(sess), .HOST_REQ_O(hreq));
   uhea_usb_far i_uhea_usb_far (.clk_i(clk), .rstn_i(rstn), .nak_mask_i(nak_mask),
      .tx_valid_i(txv), .tx_data_i(txd), .rx_ready_i(rxr), .tick_o(tick), .nak_o(nak),
      .tx_ready_o(txr), .rx_valid_o(rxv), .rx_data_o(rxd), .last_tx_o(last_tx),
      .last_ep_o(last_ep));
   //----------------------------------------------------------
   // Shared tasks
   //----------------------------------------------------------
   // Report and count one comparison
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Write; sampling at the falling edge shows what the next rising edge takes
   task automatic wr32(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, gb;
      awv <= 1'b1;
      wv <= 1'b1;
      aw <= a;
      wd <= d;
      br <= 1'b1;
      do
      begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wr;
         gb = bv;
         r = bresp;
         @(posedge clk);
         awv <= awv & ~ta;
         wv <= wv & ~tw;
      end
      while (!gb);
      br <= 1'b0;
      // Let one edge pass so a following call never drives br twice at once
      @(posedge clk);
   endtask
   // Read, holding rready until the data is seen
   task automatic rd32(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, gr;
      arv <= 1'b1;
      ar <= a;
      rr <= 1'b1;
      do
      begin
         @(negedge clk);
         ta = arv & arr;
         gr = rv;
         d = rdata;
         r = rresp;
         @(posedge clk);
         arv <= arv & ~ta;
      end
      while (!gr);
      rr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr32(a, d, r);
      chk(32'(r), 32'(RESP_OKAY));
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd32(a, d, r);
      chk(d, exp);
      chk(32'(r), 32'(RESP_OKAY));
   endtask
   // Ticks counted from the first NAK until the channel halts
   task automatic nak_halt(input int ch, input int exp);
      int n;
      logic on;
      n = 0;
      on = 1'b0;
      nak_mask[ch] <= 1'b1;
      while (!halt[ch])
      begin
         @(negedge clk);
         n += int'(on & tick);
         on |= nak[ch];
      end
      @(posedge clk);
      nak_mask[ch] <= 1'b0;
      chk(32'(n), 32'(exp));
   endtask
   // Ticks between two consecutive poll pulses
   task automatic poll_gap(input logic [11:0] ta, input logic [7:0] v, input int m,
                           input int ch, input int exp);
      int n;
      n = 0;
      wreg(ta, 32'(v));
      wreg(ta + 12'h40, 32'(m));
      do @(negedge clk); while (!pollv[ch]);
      do
      begin
         @(negedge clk);
         n += int'(tick);
      end
      while (!pollv[ch]);
      chk(32'(n), 32'(exp));
      @(posedge clk);
   endtask
   //----------------------------------------------------------
   // Scenarios
   //----------------------------------------------------------
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rchk(A_CAP, 32'h06);
      wreg(A_CAP, 32'hFF);
      rchk(A_CAP, 32'h06);
      rchk(A_RXINT + 12'h10, 32'h0);
      wreg(A_RXINT + 12'h10, 32'h5A);
      rchk(A_RXINT + 12'h10, 32'h5A);
      wr32(A_TXINT, 32'h7, r);
      chk(32'(r), 32'(RESP_SLVERR));
      rd32(A_RXINT, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      bside <= 1'b1;
      repeat (4) @(posedge clk);
      rchk(A_DEV, 32'h80);
      wreg(A_DEV, 32'h03);
      rchk(A_DEV, 32'h83);
      chk(32'({sess, hreq}), 32'h3);
      bside <= 1'b0;
      repeat (4) @(posedge clk);
      rchk(A_DEV, 32'h03);
      wreg(A_DEV, 32'h0);
      $display("done: registers");
   endtask
   // Every speed and protocol code on both type register sets
   task automatic t_types();
      logic [7:0] v;
      for (int i = 0; i < 4; i++)
      begin
         v = {i[1:0], 2'(3 - i), 4'(i + 9)};
         wreg(A_TXTYPE + 12'(4 * i), 32'(v));
         wreg(A_RXTYPE + 12'(4 * i), {24'h000000, ~v});
         rchk(A_TXTYPE + 12'(4 * i), 32'(v));
         rchk(A_RXTYPE + 12'(4 * i), {24'h000000, ~v});
         chk(32'(txt[i]), 32'(v));
         chk(32'(rxt[i]), {24'h000000, ~v});
      end
      $display("done: types");
   endtask
   task automatic t_data();
      for (int e = 0; e < 5; e++)
      begin
         wreg(A_DATA + 12'(4 * e), 32'hA5C3_0000 | 32'(e));
         chk(last_tx, 32'hA5C3_0000 | 32'(e));
         chk(32'(last_ep), 32'(e));
      end
      rchk(A_DATA + 12'h4, 32'hD001_0000);
      rchk(A_DATA + 12'h8, 32'hD002_0000);
      rchk(A_DATA + 12'h8, 32'hD002_0001);
      rchk(A_DATA, 32'h0);
      $display("done: data ports");
   endtask
   task automatic t_timers();
      wreg(A_NAK0, 32'h4);
      nak_halt(0, 8);
      rchk(A_HALT, 32'h1);
      wreg(A_HALT, 32'h1);
      rchk(A_HALT, 32'h0);
      for (int m = 0; m < 2; m++)
      begin
         wreg(A_NAK0, 32'(m));
         nak_mask[0] <= 1'b1;
         repeat (10) @(posedge tick);
         @(posedge clk);
         nak_mask[0] <= 1'b0;
         chk(32'(halt[0]), 32'h0);
      end
      // A good answer ends the stream: six NAK ticks never reach four
      wreg(A_NAK0, 32'h3);
      nak_mask[0] <= 1'b1;
      repeat (3) @(posedge tick);
      @(posedge clk);
      xok[0] <= 1'b1;
      @(posedge clk);
      xok[0] <= 1'b0;
      repeat (3) @(posedge tick);
      @(negedge clk);
      chk(32'(halt[0]), 32'h0);
      @(posedge clk);
      xok[0] <= 1'b1;
      nak_mask[0] <= 1'b0;
      @(posedge clk);
      xok[0] <= 1'b0;
      poll_gap(A_TXTYPE + 12'h4, 8'hF1, 3, 1, 3);
      poll_gap(A_TXTYPE + 12'h4, 8'hB1, 1, 1, 1);
      poll_gap(A_RXTYPE + 12'h8, 8'h52, 3, 6, 4);
      poll_gap(A_TXTYPE + 12'hC, 8'h73, 2, 3, 2);
      poll_gap(A_RXTYPE + 12'h4, 8'h51, 2, 5, 2);
      wreg(A_RXTYPE + 12'h4, 32'hA1);
      wreg(A_RXINT + 12'h4, 32'h2);
      nak_halt(5, 2);
      rchk(A_HALT, 32'h20);
      wreg(A_HALT, 32'h20);
      rchk(A_HALT, 32'h0);
      $display("done: timers");
   endtask
   //----------------------------------------------------------
   // Verdict, watchdog and main sequence
   //----------------------------------------------------------
   task automatic end_sim();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // A hang counts as a failure
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         mismatches++;
         end_sim();
      end
   end
   initial
   begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_regs();
      t_types();
      t_data();
      t_timers();
      end_sim();
   end
endmodule
